// [hdl/sfr_pkg.sv]
// shared constants and types of the spi frame register access block
package sfr_pkg;

  // frame header layout and prefetch buffer depth
  localparam int ADDR_W      = 16;       // internal address width
  localparam int CNT_W       = 15;       // byte count width
  localparam int BYTE_W      = 8;        // data unit width
  localparam int HDR_BYTES   = 4;        // header length in bytes
  localparam int DIR_BIT     = 7;        // direction flag in header byte 2
  localparam int CNT_HI_MSB  = 6;        // count bits 14:8 in header byte 2
  localparam int FIFO_DEPTH  = 4;        // read prefetch buffer depth

  // header byte positions
  localparam logic [1:0] HDR_ADDR_HI = 2'h0;
  localparam logic [1:0] HDR_ADDR_LO = 2'h1;
  localparam logic [1:0] HDR_DIR_CNT = 2'h2;
  localparam logic [1:0] HDR_CNT_LO  = 2'h3;

  // direction flag encodings
  localparam logic DIR_READ  = 1'h0;
  localparam logic DIR_WRITE = 1'h1;

  // bit counter value of the last bit of a byte
  localparam logic [2:0] BIT_LAST = 3'h7;

  // filler values
  localparam logic [BYTE_W-1:0] IDLE_BYTE = 8'h00;  // underrun / header filler

  // frame decoder states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HDR,
    ST_DATA
  } sfr_state_t;

endpackage

// [hdl/sfr_fifo.sv]
// small synchronous fifo with valid/ready on both sides and a flush
`timescale 1ns/10ps
module sfr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,        // system clock
  input  wire logic             rst,        // async reset, active high
  input  wire logic             flush,      // drop all entries
  input  wire logic             in_valid,   // write side offers a word
  output logic                  in_ready,   // room for a word
  input  wire logic [WIDTH-1:0] in_data,    // word to store
  output logic                  out_valid,  // a word is available
  input  wire logic             out_ready,  // reader takes the word
  output logic [WIDTH-1:0]      out_data    // oldest word
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } sfr_fifo_regs_t;

  sfr_fifo_regs_t q;
  sfr_fifo_regs_t d;

  // honest full and empty straight from the count
  assign in_ready  = (q.cnt != (PW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];

  // pointer and count update
  always_comb begin
    d = q;
    if (in_valid && in_ready) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == PW'(DEPTH-1)) ? '0 : q.wp + PW'(1);
    end
    if (out_valid && out_ready) begin
      d.rp = (q.rp == PW'(DEPTH-1)) ? '0 : q.rp + PW'(1);
    end
    d.cnt = q.cnt + (PW+1)'(in_valid && in_ready) - (PW+1)'(out_valid && out_ready);
    if (flush) begin
      d.wp  = '0;
      d.rp  = '0;
      d.cnt = '0;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// [hdl/sfr_spi_frame.sv]
// spi slave frame decoder turning spi frames into internal reads and writes
//
// Operation
// RQ1: frame starts at select low; address, flag, count, data follow on mosi.
// RQ2: direction flag zero means read, one means write.
// RQ3: header is 16-bit address, 1-bit flag, 15-bit count; data in bytes.
// RQ4: count of one gives a single-byte read returning exactly one byte.
// RQ5: count above one gives a burst read; only data bytes after header.
// RQ6: write header has flag set, same address and count fields.
// RQ7: writes store one byte, or count consecutive bytes as a burst.
// RQ8: after select falls, miso is driven low until read data shifts.
// RQ9: host holds mosi low after select falls in writes until header.
// RQ10: address sent high byte first, then low byte.
// RQ11: third header byte holds flag in msb and count bits 14:8 below.
// RQ12: fourth header byte holds count bits 7:0.
// RQ13: host shifts one dummy byte on mosi per read byte on miso.
// RQ14: select rises after all counted bytes; the rise ends the frame.
// RQ15: modes 0 and 3 only; sample mosi on rising, change miso on falling.
// RQ16: host holds reset at least 2 us.
// RQ17: host waits 150 ms after reset before any spi frame.
// RQ18: burst address advances by one after each data byte.
// RQ19: early select rise abandons the frame and rearms the header decoder.
`timescale 1ns/10ps
module sfr_spi_frame #(
  parameter int ADDR_W     = sfr_pkg::ADDR_W,
  parameter int CNT_W      = sfr_pkg::CNT_W,
  parameter int BYTE_W     = sfr_pkg::BYTE_W,
  parameter int FIFO_DEPTH = sfr_pkg::FIFO_DEPTH
) (
  input  wire logic              clk,              // system clock, 100 MHz
  input  wire logic              rst,              // async reset, active high
  input  wire logic              sclk,             // spi clock pin
  input  wire logic              mosi,             // spi data in pin
  input  wire logic              chip_select_low,  // spi select pin, active low
  output logic                   miso_o,           // spi data out value
  output logic                   miso_oe,          // miso driven while high
  output logic                   wr_valid,         // one-cycle write strobe
  output logic [ADDR_W-1:0]      wr_addr,          // write address
  output logic [BYTE_W-1:0]      wr_data,          // write byte
  output logic                   rd_req_valid,     // read request offered
  input  wire logic              rd_req_ready,     // read request taken
  output logic [ADDR_W-1:0]      rd_req_addr,      // read address
  input  wire logic              rd_data_valid,    // read data returned
  output logic                   rd_data_ready,    // read data accepted
  input  wire logic [BYTE_W-1:0] rd_data,          // read byte
  output logic                   busy,             // frame in progress
  output logic                   frame_done,       // pulse, frame ended cleanly
  output logic                   frame_abort,      // pulse, frame cut short
  output logic                   rd_underrun       // pulse, read byte not ready
);

  // all decoder state except the prefetch buffer in one record
  typedef struct packed {
    logic [1:0]          sclk_sy;   // sclk synchroniser
    logic [1:0]          mosi_sy;   // mosi synchroniser
    logic [1:0]          cs_sy;     // select synchroniser, active low
    logic                sclk_old;  // previous synchronised sclk
    sfr_pkg::sfr_state_t st;
    logic [2:0]          bit_cnt;   // bits of current byte taken
    logic [1:0]          hdr_idx;   // header byte index
    logic [BYTE_W-1:0]   rx_sr;     // receive shifter
    logic [BYTE_W-1:0]   tx_sr;     // transmit shifter
    logic [ADDR_W-1:0]   addr;      // current data byte address
    logic                dir;       // direction flag
    logic [CNT_W-1:0]    left;      // data bytes still to move
    logic [ADDR_W-1:0]   iss_addr;  // next prefetch address
    logic [CNT_W-1:0]    iss_left;  // prefetches still to issue
    logic                pend;      // one read outstanding
    logic                stale;     // outstanding read belongs to a dead frame
    logic                miso;
    logic                oe;
    logic                wr_v;
    logic [ADDR_W-1:0]   wr_a;
    logic [BYTE_W-1:0]   wr_d;
    logic                done;
    logic                abort;
    logic                under;
  } sfr_regs_t;

  sfr_regs_t q;
  sfr_regs_t d;

  // prefetch buffer signals
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_pop;
  logic [BYTE_W-1:0] fifo_out_data;
  logic              fifo_flush;

  // decoded pin events
  logic              sel;
  logic              rise;
  logic              fall;
  logic [BYTE_W-1:0] byte_in;
  logic              byte_done;
  logic              req_fire;
  logic              ret_fire;

  // edges and levels come only from the second synchroniser stage
  assign sel       = ~q.cs_sy[1];
  assign rise      = q.sclk_sy[1] & ~q.sclk_old;
  assign fall      = ~q.sclk_sy[1] & q.sclk_old;
  assign byte_in   = {q.rx_sr[BYTE_W-2:0], q.mosi_sy[1]};
  assign byte_done = rise && (q.bit_cnt == sfr_pkg::BIT_LAST);

  // one read in flight at a time so an abort leaves at most one stray answer
  assign rd_req_valid = sel && (q.st == sfr_pkg::ST_DATA)
                        && (q.dir == sfr_pkg::DIR_READ)
                        && (q.iss_left != '0) && !q.pend && !q.stale;
  assign rd_req_addr  = q.iss_addr;
  assign req_fire     = rd_req_valid && rd_req_ready;

  // stray answers of a dead frame are swallowed, not buffered
  assign rd_data_ready = q.stale | fifo_in_ready;
  assign fifo_in_valid = rd_data_valid & ~q.stale;
  assign ret_fire      = rd_data_valid && rd_data_ready;
  assign fifo_flush    = (q.st == sfr_pkg::ST_IDLE);

  // fifo is drained only at a byte boundary of the read data phase
  assign fifo_pop = sel && fall && (q.st == sfr_pkg::ST_DATA)
                    && (q.dir == sfr_pkg::DIR_READ)
                    && (q.left != '0) && (q.bit_cnt == '0);

  // read prefetch buffer between the internal space and the shifter
  sfr_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_prefetch (
    .clk       (clk),
    .rst       (rst),
    .flush     (fifo_flush),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (rd_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // next state of the frame decoder
  always_comb begin
    d = q;
    // two-stage synchronisers on every pin
    d.sclk_sy  = {q.sclk_sy[0], sclk};
    d.mosi_sy  = {q.mosi_sy[0], mosi};
    d.cs_sy    = {q.cs_sy[0], chip_select_low};
    d.sclk_old = q.sclk_sy[1];
    d.wr_v     = 1'b0;
    d.done     = 1'b0;
    d.abort    = 1'b0;
    d.under    = 1'b0;

    // read request and answer bookkeeping
    if (req_fire) begin
      d.pend     = 1'b1;
      d.iss_addr = q.iss_addr + ADDR_W'(1);  // [RQ18]
      d.iss_left = q.iss_left - CNT_W'(1);
    end
    if (ret_fire) begin
      d.pend  = 1'b0;
      d.stale = 1'b0;
    end

    if (!sel) begin
      // select high: frame over, decoder rearmed for a new header
      if (q.st == sfr_pkg::ST_HDR) begin
        d.abort = 1'b1;                                      // [RQ19]
      end else if (q.st == sfr_pkg::ST_DATA) begin
        d.done  = (q.left == '0);                            // [RQ14]
        d.abort = (q.left != '0);                            // [RQ19]
      end
      if (q.pend && !ret_fire) begin
        d.stale = 1'b1;
      end
      d.st       = sfr_pkg::ST_IDLE;                         // [RQ14]
      d.bit_cnt  = '0;
      d.hdr_idx  = '0;
      d.rx_sr    = '0;
      d.tx_sr    = '0;
      d.left     = '0;
      d.iss_left = '0;
      d.miso     = 1'b0;
      d.oe       = 1'b0;
    end else begin
      // select low: drive miso low until read data is shifted
      d.oe = 1'b1;                                           // [RQ8]
      if (q.st == sfr_pkg::ST_IDLE) begin
        d.st   = sfr_pkg::ST_HDR;                            // [RQ1]
        d.miso = 1'b0;                                       // [RQ8]
      end

      // mosi is sampled on rising sclk only
      if (rise) begin
        d.rx_sr   = byte_in;                                 // [RQ15]
        d.bit_cnt = q.bit_cnt + 3'h1;
      end

      // a whole byte has arrived
      if (byte_done) begin
        if (q.st != sfr_pkg::ST_DATA) begin
          // header bytes, address high first
          d.hdr_idx = q.hdr_idx + 2'h1;
          case (q.hdr_idx)
            sfr_pkg::HDR_ADDR_HI: begin
              d.addr[ADDR_W-1:BYTE_W] = byte_in;             // [RQ10]
            end
            sfr_pkg::HDR_ADDR_LO: begin
              d.addr[BYTE_W-1:0] = byte_in;                  // [RQ10]
            end
            sfr_pkg::HDR_DIR_CNT: begin
              d.dir = byte_in[sfr_pkg::DIR_BIT];             // [RQ11] [RQ2]
              d.left[CNT_W-1:BYTE_W] = byte_in[sfr_pkg::CNT_HI_MSB:0];  // [RQ11]
            end
            sfr_pkg::HDR_CNT_LO: begin
              // header complete: no further header bytes in this frame
              d.left[BYTE_W-1:0] = byte_in;                  // [RQ12] [RQ3]
              d.st       = sfr_pkg::ST_DATA;                 // [RQ5]
              d.iss_addr = q.addr;
              if (q.dir == sfr_pkg::DIR_READ) begin
                d.iss_left = {q.left[CNT_W-1:BYTE_W], byte_in};  // [RQ4] [RQ5]
              end else begin
                d.iss_left = '0;                             // [RQ6]
              end
            end
            default: begin
              d.hdr_idx = '0;
            end
          endcase
        end else if (q.left != '0) begin
          // data byte: a write byte or a dummy byte of a read
          d.addr = q.addr + ADDR_W'(1);                      // [RQ18]
          d.left = q.left - CNT_W'(1);                       // [RQ7] [RQ4]
          if (q.dir == sfr_pkg::DIR_WRITE) begin
            d.wr_v = 1'b1;                                   // [RQ7] [RQ2]
            d.wr_a = q.addr;
            d.wr_d = byte_in;
          end
        end
        // bytes past the count are ignored until select rises
      end

      // miso changes on falling sclk only
      if (fall && (q.st == sfr_pkg::ST_DATA)
          && (q.dir == sfr_pkg::DIR_READ)) begin
        if (q.left == '0) begin
          // past the counted bytes the line rests low
          d.miso = 1'b0;
        end else if (q.bit_cnt == '0) begin
          // byte boundary: load next prefetched byte, zeros if not ready
          if (fifo_out_valid) begin
            d.miso  = fifo_out_data[BYTE_W-1];               // [RQ15]
            d.tx_sr = {fifo_out_data[BYTE_W-2:0], 1'b0};
          end else begin
            d.miso  = 1'b0;
            d.tx_sr = sfr_pkg::IDLE_BYTE;
            d.under = 1'b1;
          end
        end else begin
          d.miso  = q.tx_sr[BYTE_W-1];                       // [RQ15]
          d.tx_sr = {q.tx_sr[BYTE_W-2:0], 1'b0};
        end
      end
    end
  end

  // state register; reset gives idle with miso released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // all data and status outputs come from the state register
  assign miso_o      = q.miso;
  assign miso_oe     = q.oe;
  assign wr_valid    = q.wr_v;
  assign wr_addr     = q.wr_a;
  assign wr_data     = q.wr_d;
  assign busy        = (q.st != sfr_pkg::ST_IDLE);
  assign frame_done  = q.done;
  assign frame_abort = q.abort;
  assign rd_underrun = q.under;

endmodule

// [dv/sfr_spi_frame_assertions.sv]
// port-level checker for the spi frame decoder
`timescale 1ns/10ps
module sfr_spi_frame_checker #(
  parameter int ADDR_W = sfr_pkg::ADDR_W
) (
  input wire logic              clk,              // system clock
  input wire logic              rst,              // async reset
  input wire logic              sclk,             // link clock pin
  input wire logic              chip_select_low,  // select pin
  input wire logic              miso_o,           // miso value
  input wire logic              miso_oe,          // miso enable
  input wire logic              wr_valid,         // write strobe
  input wire logic [ADDR_W-1:0] wr_addr,          // write address
  input wire logic              rd_req_valid,     // read request
  input wire logic              rd_req_ready,     // request taken
  input wire logic [ADDR_W-1:0] rd_req_addr,      // read address
  input wire logic              rd_data_ready,    // answer taken
  input wire logic              busy,             // frame active
  input wire logic              frame_done,       // clean end
  input wire logic              frame_abort       // early end
);
  logic [ADDR_W-1:0] rd_prev_q;
  logic [ADDR_W-1:0] wr_prev_q;
  logic              rd_have_q;
  logic              wr_have_q;

  // last address of this frame; cleared at frame end so a new header restarts the step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_prev_q <= '0;
      wr_prev_q <= '0;
      rd_have_q <= 1'b0;
      wr_have_q <= 1'b0;
    end else if (frame_done || frame_abort) begin
      rd_have_q <= 1'b0;
      wr_have_q <= 1'b0;
    end else begin
      if (rd_req_valid && rd_req_ready) begin
        rd_prev_q <= rd_req_addr;
        rd_have_q <= 1'b1;
      end
      if (wr_valid) begin
        wr_prev_q <= wr_addr;
        wr_have_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // eight cycles leave room for the pin synchronisers
  oe_idle_a: assert property (chip_select_low [*8] |-> !miso_oe)
    else $error("miso driven while deselected");
  oe_frame_a: assert property (!chip_select_low [*8] |-> miso_oe)
    else $error("miso not driven in frame");
  end_pulse_a: assert property ((frame_done || frame_abort) |->
    chip_select_low && $past(chip_select_low) && !(frame_done && frame_abort)) else $error("bad frame end pulse");
  miso_edge_a: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |->
    !$past(sclk) && !$past(sclk, 2)) else $error("miso moved outside low sclk");
  wr_space_a: assert property (wr_valid |=> !wr_valid [*8])
    else $error("write strobes too close");
  // a select rise one cycle back withdraws the request, which is legal
  rd_hold_a: assert property (rd_req_valid && !rd_req_ready && !$past(chip_select_low) |=>
    rd_req_valid && $stable(rd_req_addr))
    else $error("read request dropped or moved");
  rd_single_a: assert property (rd_req_valid && rd_req_ready |=> !rd_req_valid)
    else $error("second read request outstanding");
  rd_step_a: assert property (rd_req_valid && rd_req_ready && rd_have_q |->
    rd_req_addr == ADDR_W'(rd_prev_q + 1'b1)) else $error("read address step wrong");
  wr_step_a: assert property (wr_valid && wr_have_q |-> wr_addr == ADDR_W'(wr_prev_q + 1'b1))
    else $error("write address step wrong");
  idle_quiet_a: assert property (!busy [*3] |-> !rd_req_valid)
    else $error("read request while idle");

  cover property (frame_done);
  cover property (frame_abort);
  cover property (busy && !rd_data_ready);
  cover property (wr_valid && wr_have_q);
endmodule

bind sfr_spi_frame sfr_spi_frame_checker #(.ADDR_W(ADDR_W)) u_chk (
  .clk(clk), .rst(rst), .sclk(sclk), .chip_select_low(chip_select_low), .miso_o(miso_o),
  .miso_oe(miso_oe), .wr_valid(wr_valid), .wr_addr(wr_addr), .rd_req_valid(rd_req_valid),
  .rd_req_ready(rd_req_ready), .rd_req_addr(rd_req_addr), .rd_data_ready(rd_data_ready),
  .busy(busy), .frame_done(frame_done), .frame_abort(frame_abort));

// [dv/sfr_host_model.sv]
// behavioural spi master, mode 0, paced by the bench clock
`timescale 1ns/10ps
module sfr_host_model (
  input  wire logic clk,              // bench clock
  input  wire logic miso,             // resolved miso line
  output logic      sclk,             // link clock, still outside frames
  output logic      mosi,             // host data out
  output logic      chip_select_low   // select, active low
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    chip_select_low = 1'b1;
  end

  // released mosi toggles so a stale level cannot pass for data
  always @(posedge clk) begin
    if (chip_select_low) begin
      mosi <= ~mosi;
    end
  end

  // half of the 160 ns link period
  task automatic half();
    repeat (8) @(posedge clk);
    #1;
  endtask

  // mosi parked low until the header starts
  task automatic select(input logic on);
    chip_select_low = ~on;
    mosi = 1'b0;
    half();
  endtask

  // one byte, msb first; sample on rise, shift on fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      half();
      sclk = 1'b1;
      rx[i] = miso;
      half();
      sclk = 1'b0;
    end
  endtask
endmodule

// [dv/tb.sv]
// self-checking bench for the spi frame decoder
`timescale 1ns/10ps
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sclk, mosi, chip_select_low, miso_o, miso_oe, miso, wr_valid, rd_req_valid, rd_data_ready;
  logic        busy, frame_done, frame_abort, rd_underrun;
  logic        float_q = 1'b0;
  logic        rd_req_ready = 1'b0;
  logic        rd_data_valid = 1'b0;
  logic [15:0] wr_addr, rd_req_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data = 8'h00;
  logic [23:0] exp_wr[$], got_wr[$];
  int          n_mismatch = 0, checks = 0, seed = 32'h0dd6, n_done = 0, n_abort = 0, n_under = 0;
  int          t_dir[9] = '{1, 0, 1, 0, 1, 1, 0, 1, 0};
  int          t_cnt[9] = '{1, 1, 3, 7, 0, 258, 3, 2, 1};
  int          t_cut[9] = '{99, 99, 99, 99, 99, 6, 5, 2, 99};

  always #5 clk = ~clk;
  // undriven miso shows a changing pattern
  always @(posedge clk) float_q <= ~float_q;
  assign miso = miso_oe ? miso_o : float_q;

  sfr_host_model u_host (.clk(clk), .miso(miso), .sclk(sclk), .mosi(mosi), .chip_select_low(chip_select_low));
  sfr_spi_frame DUT (.clk(clk), .rst(rst), .sclk(sclk), .mosi(mosi), .chip_select_low(chip_select_low),
    .miso_o(miso_o), .miso_oe(miso_oe), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready), .rd_req_addr(rd_req_addr),
    .rd_data_valid(rd_data_valid), .rd_data_ready(rd_data_ready), .rd_data(rd_data), .busy(busy),
    .frame_done(frame_done), .frame_abort(frame_abort), .rd_underrun(rd_underrun));

  // contents of the internal space as the read port serves it
  function automatic logic [7:0] mem_val(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h3C;
  endfunction

  task automatic tally_and_finish();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // observed strobes and pulses
  always @(posedge clk) begin
    if (wr_valid === 1'b1) got_wr.push_back({wr_addr, wr_data});
    if (frame_done === 1'b1) n_done++;
    if (frame_abort === 1'b1) n_abort++;
    if (rd_underrun === 1'b1) n_under++;
  end

  // read port: random accept, answer 1 or 2 cycles later, held until taken
  initial begin : rd_port
    logic [15:0] a;
    logic        hit;
    forever begin
      // sample mid-cycle: combinational valid would race the edge that takes it
      @(negedge clk);
      hit = (rd_req_valid === 1'b1) && (rd_req_ready === 1'b1);
      a = rd_req_addr;
      @(posedge clk);
      if (hit) begin
        #1 rd_req_ready = 1'b0;
        repeat ((seed & 1) + 1) @(posedge clk);
        #1 rd_data_valid = 1'b1;
        rd_data = mem_val(a);
        for (int k = 0; k < 500; k++) begin
          @(negedge clk);
          hit = (rd_data_ready === 1'b1);
          @(posedge clk);
          if (hit) break;
          if (k == 499) begin
            n_mismatch++;
            tally_and_finish();
          end
        end
        #1 rd_data_valid = 1'b0;
        rd_data = ~rd_data;
      end else #1 rd_req_ready = 1'(($random(seed) & 3) != 0);
    end
  end

  // one frame with the host model; cut stops it after that many bytes
  task automatic frame(input logic dir, input logic [15:0] a, input int cnt, input int cut);
    logic [7:0] hdr[4];
    logic [7:0] tx, rx;
    int         d0, a0;
    hdr = '{a[15:8], a[7:0], {dir, 7'(cnt >> 8)}, 8'(cnt)};
    d0 = n_done;
    a0 = n_abort;
    exp_wr.delete();
    got_wr.delete();
    u_host.select(1'b1);
    for (int i = 0; i < 4 + cnt && i < cut; i++) begin
      tx = (i < 4) ? hdr[i] : (dir ? 8'($random(seed)) : 8'h00);
      u_host.xfer(tx, rx);
      if (i < 4 && !dir) check(24'(rx), 24'h000000);
      if (i >= 4 && !dir) check(24'(rx), 24'(mem_val(a + 16'(i - 4))));
      if (i >= 4 && dir) exp_wr.push_back({a + 16'(i - 4), tx});
    end
    u_host.select(1'b0);
    check(24'(busy), 24'h000000);
    check(24'(got_wr.size()), 24'(exp_wr.size()));
    foreach (exp_wr[j]) if (j < got_wr.size()) check(got_wr[j], exp_wr[j]);
    check(24'(n_done - d0), 24'(cut >= 4 + cnt));
    check(24'(n_abort - a0), 24'(cut < 4 + cnt));
  endtask

  initial begin : main
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);  // settle wait scaled to the synchronisers
    for (int k = 0; k < 9; k++) begin
      if (k == 5) begin
        rst = 1'b1;
        repeat (200) @(posedge clk);  // 2 us reset pulse
        #1 rst = 1'b0;
        repeat (6) @(posedge clk);
      end
      frame(1'(t_dir[k]), (k == 2) ? 16'hFFFE : 16'($random(seed)), t_cnt[k], t_cut[k]);
    end
    check(24'(n_under), 24'h000000);
    tally_and_finish();
  end
endmodule
